//--- tsxl_addr.sv
// tsxl_addr.sv: data address former for the register-test instruction
// assumes: fsr2 value is supplied by the core's indirect registers
`include "tsxl_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tsxl_addr (
  // operand
  input  wire logic [7:0]  reg_field_i,
  input  wire logic        bank_bit_i,
  // core state
  input  wire logic        ext_set_en_i,
  input  wire logic [3:0]  bank_select_reg_i,
  input  wire logic [11:0] fsr2_i,
  // result
  output logic      [11:0] addr_o
);
  always_comb begin
    if (!bank_bit_i && ext_set_en_i && reg_field_i <= `TSXL_ILO_MAX) begin
      addr_o = 12'(fsr2_i + {4'h0, reg_field_i});
    end else if (bank_bit_i) begin
      addr_o = {bank_select_reg_i, reg_field_i};
    end else if (reg_field_i < `TSXL_ACC_SPLIT) begin
      addr_o = {4'h0, reg_field_i};
    end else begin
      addr_o = {`TSXL_ACC_HI_BANK, reg_field_i};
    end
  end
endmodule
`default_nettype wire

//--- tsxl_core.sv
// tsxl_core.sv: decode/execute of register test-skip and xor-literal
// assumes: one instruction word per instruction cycle of four q phases;
// reg data answers in the phase after addr is presented; the core tells
// whether the fetched next word starts a two-word instruction.
// Summary of operation
// - register zero: discard fetched next instruction, run nop; no flags
// - decode test opcode; bank bit 0 access bank, 1 bank select reg
// - indexed offset when bank bit 0, extended set on, field <= 95
// - test takes 1 cycle, 2 with skip, 3 skipping two-word op
// - decode xor-literal opcode, xor low-byte literal with accumulator
// - write result to accumulator, update only n and z, one cycle
`include "tsxl_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tsxl_core (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  // fetch side
  input  wire logic [15:0] instr_i,
  input  wire logic        instr_valid_i,
  input  wire logic        next_two_word_i,
  // core state
  input  wire logic        ext_set_en_i,
  input  wire logic [3:0]  bank_select_reg_i,
  input  wire logic [11:0] fsr2_i,
  input  wire logic [7:0]  reg_rdata_i,
  // outputs
  output logic      [11:0] reg_addr_o,
  output logic             reg_rd_o,
  output logic      [7:0]  accum_o,
  output logic             flag_n_o,
  output logic             flag_z_o,
  output logic             flags_we_o,
  output logic             pc_inc_o,
  output logic             nop_cycle_o,
  output logic             busy_o,
  output logic      [1:0]  q_phase_o
);
  logic [1:0]           q_reg;
  tsxl_pkg::tsxl_state_t state_reg;
  logic [15:0]          ir_reg;
  logic [15:0]          dec_word;
  logic [11:0]          addr_next;
  logic                 is_tst;
  logic                 is_xor;
  logic                 dec_tst;
  logic                 two_word_reg;
  logic [7:0]           xor_next;
  logic                 cyc_end;
  logic                 take_instr;
  logic                 exec_xor;
  logic                 skip_hit;
  logic                 skip_more;
  logic                 skip_next;

  assign cyc_end = (q_reg == `TSXL_Q_LAST);
  // word at q0 is not yet in ir_reg, so decode it from the fetch port
  assign dec_word = instr_valid_i ? instr_i : 16'h0000;
  assign take_instr = (q_reg == `TSXL_Q_FIRST) &&
                      (state_reg == tsxl_pkg::TSXL_EXEC);
  assign is_tst = ((ir_reg & `TSXL_OPC_TST_MASK) ==
                   `TSXL_OPC_TST_VAL);
  assign is_xor = ((ir_reg & `TSXL_OPC_XOR_MASK) ==
                   `TSXL_OPC_XOR_VAL);
  assign dec_tst = ((dec_word & `TSXL_OPC_TST_MASK) ==
                    `TSXL_OPC_TST_VAL);
  assign xor_next = accum_o ^ ir_reg[7:0];
  assign exec_xor = (state_reg == tsxl_pkg::TSXL_EXEC) && is_xor;
  assign skip_hit = (state_reg == tsxl_pkg::TSXL_EXEC) && is_tst &&
                    (reg_rdata_i == `TSXL_ZERO8);
  assign skip_more = (state_reg == tsxl_pkg::TSXL_SKIP1) && two_word_reg;
  assign skip_next = skip_hit || skip_more;

  tsxl_addr tsxl_addr_inst (
    .reg_field_i       (dec_word[7:0]),
    .bank_bit_i        (dec_word[`TSXL_BANK_BIT]),
    .ext_set_en_i      (ext_set_en_i),
    .bank_select_reg_i (bank_select_reg_i),
    .fsr2_i            (fsr2_i),
    .addr_o            (addr_next)
  );

  // q phase counter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q_reg <= `TSXL_Q_FIRST;
    end else if (ce_i) begin
      q_reg <= q_reg + `TSXL_Q_STEP;
    end
  end
  assign q_phase_o = q_reg;

  // instruction register, latched at q0 of an executing cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ir_reg <= 16'h0000;
    end else if (ce_i && take_instr) begin
      ir_reg <= dec_word;
    end
  end

  // whether the word behind this one is a two-word instruction
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      two_word_reg <= 1'b0;
    end else if (ce_i && take_instr) begin
      two_word_reg <= next_two_word_i;
    end
  end

  // skip sequencer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= tsxl_pkg::TSXL_EXEC;
    end else if (ce_i && cyc_end) begin
      case (state_reg)
        tsxl_pkg::TSXL_EXEC: begin
          if (skip_hit) begin
            state_reg <= tsxl_pkg::TSXL_SKIP1;
          end
        end
        tsxl_pkg::TSXL_SKIP1: begin
          if (two_word_reg) begin
            state_reg <= tsxl_pkg::TSXL_SKIP2;
          end else begin
            state_reg <= tsxl_pkg::TSXL_EXEC;
          end
        end
        tsxl_pkg::TSXL_SKIP2: begin
          state_reg <= tsxl_pkg::TSXL_EXEC;
        end
        default: begin
          state_reg <= tsxl_pkg::TSXL_EXEC;
        end
      endcase
    end
  end

  // read strobe: one clock in q1 of a test instruction
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rd_o <= 1'b0;
    end else if (ce_i) begin
      reg_rd_o <= take_instr && dec_tst;
    end
  end

  // data address of the word taken at q0, held through q3
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_addr_o <= 12'h000;
    end else if (ce_i && take_instr) begin
      reg_addr_o <= addr_next;
    end
  end

  // accumulator: only xor-literal writes it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      accum_o <= 8'h00;
    end else if (ce_i && cyc_end && exec_xor) begin
      accum_o <= xor_next;
    end
  end

  // negative flag follows the result's sign bit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_n_o <= 1'b0;
    end else if (ce_i && cyc_end && exec_xor) begin
      flag_n_o <= xor_next[`TSXL_SIGN_BIT];
    end
  end

  // zero flag; the test instruction leaves it alone
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_z_o <= 1'b0;
    end else if (ce_i && cyc_end && exec_xor) begin
      flag_z_o <= (xor_next == `TSXL_ZERO8);
    end
  end

  // flag write strobe, one clock per xor-literal
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags_we_o <= 1'b0;
    end else if (ce_i) begin
      flags_we_o <= cyc_end && exec_xor;
    end
  end

  // pc advance: one pulse per instruction cycle, skip cycles included
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pc_inc_o <= 1'b0;
    end else if (ce_i) begin
      pc_inc_o <= cyc_end;
    end
  end

  // nop flag: stands for the whole coming instruction cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      nop_cycle_o <= 1'b0;
    end else if (ce_i && cyc_end) begin
      nop_cycle_o <= skip_next;
    end
  end

  // busy while a skip cycle runs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
    end else if (ce_i && cyc_end) begin
      busy_o <= skip_next;
    end
  end
endmodule
`default_nettype wire

//--- tsxl_core_asserts.sv
// tsxl_core_asserts.sv: port checker for tsxl_core
// assumes: bound to tsxl_core, ce_i held high
`timescale 1ns/100ps
`default_nettype none
module tsxl_core_asserts (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [15:0] instr_i,
  input wire logic [3:0]  bank_select_reg_i,
  input wire logic [11:0] reg_addr_o,
  input wire logic        reg_rd_o,
  input wire logic [7:0]  accum_o,
  input wire logic        flag_n_o,
  input wire logic        flag_z_o,
  input wire logic        flags_we_o,
  input wire logic        pc_inc_o,
  input wire logic        nop_cycle_o,
  input wire logic [1:0]  q_phase_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  zero_flag_a: assert property (
    flags_we_o |-> flag_z_o == (accum_o == 8'h00))
    else $error("zero flag wrong");
  neg_flag_a: assert property (
    flags_we_o |-> flag_n_o == accum_o[7])
    else $error("negative flag wrong");
  acc_write_a: assert property (
    $changed(accum_o) |-> flags_we_o)
    else $error("accumulator changed without write");
  pc_cadence_a: assert property (
    pc_inc_o |=> !pc_inc_o [*3] ##1 pc_inc_o)
    else $error("instruction cycle not four clocks");
  rd_phase_a: assert property (
    reg_rd_o |-> q_phase_o == 2'h1)
    else $error("register read outside q1");
  bank_sel_a: assert property (
    reg_rd_o && $past(instr_i[8])
      |-> reg_addr_o[11:8] == bank_select_reg_i)
    else $error("bank select not used");
  nop_quiet_a: assert property (
    nop_cycle_o |-> !flags_we_o && !reg_rd_o)
    else $error("skip cycle did work");
  skip_len_a: assert property (
    $rose(nop_cycle_o) |-> nop_cycle_o [*4])
    else $error("skip cycle too short");
endmodule
`default_nettype wire

//--- tsxl_core_tb_top.sv
// tsxl_core_tb_top.sv: directed bench for tsxl_core
// assumes: regfile model answers combinationally
`timescale 1ns/100ps
`default_nettype none
module tsxl_core_tb_top;
  logic clk_i = 1'b0, srst_i = 1'b1, two = 1'b0, ext = 1'b1;
  logic [15:0] instr_i = 16'h0000;
  logic [3:0] bank_select_reg = 4'h3;
  logic [11:0] fsr2 = 12'hff0, zaddr = 12'hf60, addr;
  logic [7:0] rdata, acc;
  logic n, z, nop, busy;
  logic [11:0] ex_q = 12'h000;
  int num_errors = 0, samples_checked = 0;
  initial forever #5 clk_i = ~clk_i;
  tsxl_regfile_model tsxl_regfile_model_inst (.addr_i(addr),
    .zero_addr_i(zaddr), .rdata_o(rdata));
  tsxl_core tsxl_core_inst (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
    .instr_i(instr_i), .instr_valid_i(1'b1), .next_two_word_i(two),
    .ext_set_en_i(ext), .bank_select_reg_i(bank_select_reg), .fsr2_i(fsr2),
    .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_rd_o(), .accum_o(acc),
    .flag_n_o(n), .flag_z_o(z), .flags_we_o(), .pc_inc_o(),
    .nop_cycle_o(nop), .busy_o(busy), .q_phase_o());
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one instruction cycle, called at the edge before q0; ex packs busy,
  // n, z, nop, accum and is checked one call later, while it stands
  task automatic run(input logic [15:0] w, input logic t,
                     input logic [11:0] ea, input logic [11:0] ex);
    instr_i <= w;
    two <= t;
    @(posedge clk_i);
    @(negedge clk_i);
    chk({busy, n, z, nop, acc}, ex_q);
    if (w[15:9] == 7'h33) chk(addr, ea);
    ex_q = ex;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic conclude;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    run(16'h0a80, 1'b0, 12'h000, 12'h480);
    run(16'h0a80, 1'b0, 12'h000, 12'h200);
    run(16'h6712, 1'b0, 12'h312, 12'h200);
    run(16'h665f, 1'b0, 12'h04f, 12'h200);
    run(16'h6660, 1'b0, 12'hf60, 12'hb00);
    run(16'h0aff, 1'b0, 12'h000, 12'h200);
    run(16'h6660, 1'b1, 12'hf60, 12'hb00);
    run(16'h0aff, 1'b0, 12'h000, 12'hb00);
    run(16'h0aff, 1'b0, 12'h000, 12'h200);
    run(16'h0a01, 1'b0, 12'h000, 12'h001);
    ext <= 1'b0;
    run(16'h665f, 1'b0, 12'h05f, 12'h001);
    @(negedge clk_i);
    chk({busy, n, z, nop, acc}, ex_q);
    conclude();
  end
  initial begin
    repeat (400) @(posedge clk_i);
    num_errors++;
    conclude();
  end
endmodule
bind tsxl_core tsxl_core_asserts tsxl_core_asserts_inst (.clk_i(clk_i),
  .srst_i(srst_i), .instr_i(instr_i), .bank_select_reg_i(bank_select_reg_i),
  .reg_addr_o(reg_addr_o), .reg_rd_o(reg_rd_o), .accum_o(accum_o),
  .flag_n_o(flag_n_o), .flag_z_o(flag_z_o), .flags_we_o(flags_we_o),
  .pc_inc_o(pc_inc_o), .nop_cycle_o(nop_cycle_o), .q_phase_o(q_phase_o));
`default_nettype wire

//--- tsxl_params.svh
// tsxl_params.svh: constants for the test-skip / xor-literal execute block
// assumes: included by bare name from the design files
`ifndef TSXL_PARAMS_SVH
`define TSXL_PARAMS_SVH
`define TSXL_OPC_TST_MASK  16'hfe00
`define TSXL_OPC_TST_VAL   16'h6600
`define TSXL_OPC_XOR_MASK  16'hff00
`define TSXL_OPC_XOR_VAL   16'h0a00
`define TSXL_BANK_BIT      8
`define TSXL_ILO_MAX       8'h5f
`define TSXL_ACC_SPLIT     8'h60
`define TSXL_ACC_HI_BANK   4'hf
`define TSXL_ZERO8         8'h00
`define TSXL_Q_LAST        2'h3
`define TSXL_Q_READ        2'h1
`define TSXL_Q_FIRST       2'h0
`define TSXL_Q_STEP        2'h1
`define TSXL_SIGN_BIT      7
`endif

//--- tsxl_pkg.sv
// tsxl_pkg.sv: types for the test-skip / xor-literal execute block
// assumes: nothing
package tsxl_pkg;
  typedef enum logic [1:0] {
    TSXL_EXEC,
    TSXL_SKIP1,
    TSXL_SKIP2
  } tsxl_state_t;
endpackage

//--- tsxl_regfile_model.sv
// tsxl_regfile_model.sv: data memory seen by the core
// assumes: one address reads zero, all others nonzero
`timescale 1ns/100ps
`default_nettype none
module tsxl_regfile_model (
  input  wire logic [11:0] addr_i,
  input  wire logic [11:0] zero_addr_i,
  output logic      [7:0]  rdata_o
);
  assign rdata_o = (addr_i == zero_addr_i) ? 8'h00 : (addr_i[7:0] | 8'h01);
endmodule
`default_nettype wire
